/* common/crc_pkg.sv */
// package: command codes, role values, threshold defaults and carriers for the cold-redundancy block
`default_nettype none
package crc_pkg;

    // management-bus command codes
    localparam logic [7:0] CMD_ROLE        = 8'hd0;
    localparam logic [7:0] CMD_WAKE_POS1   = 8'hd1;
    localparam logic [7:0] CMD_SLEEP_POS1  = 8'hd2;
    localparam logic [7:0] CMD_WAKE_POS2   = 8'hd3;
    localparam logic [7:0] CMD_SLEEP_POS2  = 8'hd4;
    localparam logic [7:0] CMD_WAKE_POS3   = 8'hd5;
    localparam logic [7:0] CMD_SLEEP_POS3  = 8'hd6;
    localparam logic [7:0] CMD_STATUS      = 8'hd7;

    // role byte values
    localparam logic [7:0] ROLE_STANDARD   = 8'h00;
    localparam logic [7:0] ROLE_CR_ACTIVE  = 8'h01;
    localparam logic [7:0] ROLE_STBY1      = 8'h02;
    localparam logic [7:0] ROLE_STBY3      = 8'h04;
    localparam logic [7:0] ROLE_ALWAYS_SB  = 8'h05;
    localparam logic [7:0] ROLE_RESET      = ROLE_STANDARD;

    // thresholds: 8-bit code, 8.0 V load share (full rated power) = 256 codes
    localparam int         THR_ENTRIES     = 6;
    localparam logic [7:0] THR_WAKE1_RST   = 8'h66;  // 3.2 V
    localparam logic [7:0] THR_SLEEP1_RST  = 8'h2e;  // 1.44 V
    localparam logic [7:0] THR_WAKE2_RST   = 8'ha0;  // 5.0 V
    localparam logic [7:0] THR_SLEEP2_RST  = 8'h60;  // 3.0 V
    localparam logic [7:0] THR_WAKE3_RST   = 8'hd6;  // 6.7 V
    localparam logic [7:0] THR_SLEEP3_RST  = 8'h90;  // 4.52 V
    localparam logic [THR_ENTRIES*8-1:0] THR_RST_VEC = {
        THR_SLEEP3_RST, THR_WAKE3_RST, THR_SLEEP2_RST,
        THR_WAKE2_RST, THR_SLEEP1_RST, THR_WAKE1_RST};

    // status byte bit positions
    localparam int ST_CONV_ON     = 0;
    localparam int ST_WAKE_LEVEL  = 1;
    localparam int ST_LOAD_AWAKE  = 2;
    localparam int ST_DRIVE_LOW   = 3;
    localparam int ST_DRIVE_HIGH  = 4;
    localparam int ST_FAULT       = 5;

    // timing
    localparam int CLK_PERIOD_NS      = 100;
    localparam int WAKE_RESPONSE_US   = 100;
    localparam int WAKE_RESPONSE_CYC  = (WAKE_RESPONSE_US * 1000) / CLK_PERIOD_NS;
    localparam int SYNC_BITS          = 5;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       pec_ok;
        logic [7:0] code;
        logic [7:0] wdata;
    } crc_cmd_t;

    typedef struct packed {
        logic       ack;
        logic       nak;
        logic [7:0] rdata;
    } crc_rsp_t;

    typedef enum logic [1:0] {
        CS_FORCED_ON,
        CS_ASLEEP,
        CS_LOAD_ON
    } crc_conv_state_t;

    // threshold command decode, shared by the bank and the top
    function automatic logic thr_hit(input logic [7:0] code);
        return (code >= CMD_WAKE_POS1) && (code <= CMD_SLEEP_POS3);
    endfunction

    function automatic logic [2:0] thr_index(input logic [7:0] code);
        logic [7:0] d;
        d = code - CMD_WAKE_POS1;
        return d[2:0];
    endfunction

endpackage
`default_nettype wire

/* hdl/crc_sync.sv */
// two-flop synchroniser for a vector of independent level inputs
`default_nettype none
module crc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (rst) begin
                    meta_reg[i] <= 1'b0;
                    sync_reg[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= d[i];
                    sync_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    assign q = sync_reg;
endmodule
`default_nettype wire

/* hdl/crc_thresh_bank.sv */
// programmable wake/sleep threshold bank for the three standby positions
`default_nettype none
module crc_thresh_bank
    import crc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_code,
    input  wire logic [7:0] wr_data,
    input  wire logic [7:0] rd_code,
    input  wire logic [1:0] position,
    output logic      [7:0] rd_data,
    output logic      [7:0] wake_thr,
    output logic      [7:0] sleep_thr
);
    logic [7:0] thr_reg [THR_ENTRIES];
    logic [7:0] wake_reg;
    logic [7:0] sleep_reg;
    wire  [2:0] wr_idx  = thr_index(wr_code);
    wire  [2:0] rd_idx  = thr_index(rd_code);
    wire  [2:0] wake_i  = {position, 1'b0};
    wire  [2:0] sleep_i = {position, 1'b1};

    genvar i;
    generate
        for (i = 0; i < THR_ENTRIES; i++) begin : g_thr
            always_ff @(posedge clk) begin
                if (rst) begin
                    thr_reg[i] <= THR_RST_VEC[i*8 +: 8];
                end else if (wr_en && thr_hit(wr_code) && wr_idx == 3'(i)) begin
                    thr_reg[i] <= wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            wake_reg  <= THR_WAKE1_RST;
            sleep_reg <= THR_SLEEP1_RST;
        end else begin
            wake_reg  <= thr_reg[wake_i];
            sleep_reg <= thr_reg[sleep_i];
        end
    end

    assign rd_data   = thr_hit(rd_code) ? thr_reg[rd_idx] : 8'h00;
    assign wake_thr  = wake_reg;
    assign sleep_thr = sleep_reg;
endmodule
`default_nettype wire

/* hdl/crc_controller.sv */
// cold-redundancy role controller: role byte, wake-line drive and converter enable
`default_nettype none
// How it works
// - pull the wake line low on internal fault or output undervoltage
// - a cold standby role turns the converter on while the wake line is low
// - no active supply driving the line high means the line reads low, converter on
// - standby only holds while some peer keeps the line high; system arranges roles
// - role byte resets to 00h so every supply starts with its converter on
// - standby converter off only for line high and, in roles 02h..04h, load below wake threshold
// - standby compares load share against a bus-programmed threshold for its position
// - default wake thresholds 3.2 V, 5.0 V, 6.7 V, reprogrammable per position
// - default sleep thresholds 90% of wake scaled by k/(k+1)
// - threshold codes scaled so 8.0 V load share is full rated power
// - standard and active roles ignore the enable and keep converter on
// - standard and standby roles leave the line released when healthy, low on fault
// - active role 01h drives the line high when healthy, low on fault
// - converter turns on within 100 us of the wake line falling
// - role byte read and written at command D0h, writes only with good packet check
// - roles 02h..04h select standby positions one to three
// - role 05h stays in standby whatever the load share
// - falling wake line rewrites a standby role to standard redundancy 00h
module crc_controller
    import crc_pkg::*;
(
    input  wire logic       MCLK,
    input  wire logic       RESET,
    input  wire crc_cmd_t   CMD_REQ,
    output crc_rsp_t        CMD_RSP,
    input  wire logic       FAULT,
    input  wire logic       OUT_UNDERVOLT,
    input  wire logic       LOAD_ABOVE_WAKE,
    input  wire logic       LOAD_ABOVE_SLEEP,
    input  wire logic       WAKE_LINE_IN,
    output logic            WAKE_LINE_OUT,
    output logic            WAKE_LINE_OE,
    output logic      [7:0] WAKE_THRESHOLD,
    output logic      [7:0] SLEEP_THRESHOLD,
    output logic            CONVERTER_ON_N
);
    // role helpers
    function automatic logic is_standby(input logic [7:0] r);
        return (r >= ROLE_STBY1) && (r <= ROLE_ALWAYS_SB);
    endfunction

    function automatic logic is_positioned(input logic [7:0] r);
        return (r >= ROLE_STBY1) && (r <= ROLE_STBY3);
    endfunction

    // synchronised inputs
    logic [SYNC_BITS-1:0] async_in;
    logic [SYNC_BITS-1:0] sync_out;
    logic                 wake_s;
    logic                 fault_s;
    logic                 uv_s;
    logic                 above_wake_s;
    logic                 above_sleep_s;

    // state
    logic [7:0]      role_reg;
    logic [7:0]      role_next;
    crc_conv_state_t state_reg;
    crc_conv_state_t state_next;
    logic            wake_prev_reg;
    logic            conv_on_n_reg;
    logic            conv_on_n_next;
    logic            drv_out_reg;
    logic            drv_oe_reg;
    crc_rsp_t        rsp_reg;
    crc_rsp_t        rsp_next;

    assign async_in = {LOAD_ABOVE_SLEEP, LOAD_ABOVE_WAKE, OUT_UNDERVOLT, FAULT, WAKE_LINE_IN};

    crc_sync #(
        .W (SYNC_BITS)
    ) u_sync (
        .clk (MCLK),
        .rst (RESET),
        .d   (async_in),
        .q   (sync_out)
    );

    assign wake_s        = sync_out[0];
    assign fault_s       = sync_out[1];
    assign uv_s          = sync_out[2];
    assign above_wake_s  = sync_out[3];
    assign above_sleep_s = sync_out[4];

    // decode
    wire        any_fault   = fault_s | uv_s;
    wire        wake_fall   = wake_prev_reg & ~wake_s;
    wire        wake_low    = ~wake_s;
    wire        cmd_wr      = CMD_REQ.valid & CMD_REQ.write;
    wire        cmd_rd      = CMD_REQ.valid & ~CMD_REQ.write;
    wire        pec_good    = CMD_REQ.pec_ok;
    wire        role_cmd    = (CMD_REQ.code == CMD_ROLE);
    wire        thr_cmd     = thr_hit(CMD_REQ.code);
    wire        stat_cmd    = (CMD_REQ.code == CMD_STATUS);
    wire        role_val_ok = (CMD_REQ.wdata <= ROLE_ALWAYS_SB);
    wire        role_wr     = cmd_wr & pec_good & role_cmd & role_val_ok;
    wire        thr_wr      = cmd_wr & pec_good & thr_cmd;
    wire        standby     = is_standby(role_reg);
    wire        positioned  = is_positioned(role_reg);
    wire [7:0]  pos_off     = role_reg - ROLE_STBY1;
    wire [1:0]  position    = positioned ? pos_off[1:0] : 2'b00;
    wire [7:0]  thr_rdata;
    wire [7:0]  status_byte;

    crc_thresh_bank u_thr (
        .clk       (MCLK),
        .rst       (RESET),
        .wr_en     (thr_wr),
        .wr_code   (CMD_REQ.code),
        .wr_data   (CMD_REQ.wdata),
        .rd_code   (CMD_REQ.code),
        .position  (position),
        .rd_data   (thr_rdata),
        .wake_thr  (WAKE_THRESHOLD),
        .sleep_thr (SLEEP_THRESHOLD)
    );

    // role byte; a falling wake line wins over a simultaneous write
    always_comb begin
        role_next = role_reg;
        if (wake_fall && standby) begin
            role_next = ROLE_STANDARD;
        end else if (role_wr) begin
            role_next = CMD_REQ.wdata;
        end
    end

    // converter state
    always_comb begin
        state_next = state_reg;
        if (!standby) begin
            state_next = CS_FORCED_ON;
        end else if (role_reg == ROLE_ALWAYS_SB) begin
            state_next = CS_ASLEEP;
        end else begin
            unique case (state_reg)
                CS_FORCED_ON: begin
                    state_next = above_sleep_s ? CS_LOAD_ON : CS_ASLEEP;
                end
                CS_ASLEEP: begin
                    if (above_wake_s) begin
                        state_next = CS_LOAD_ON;
                    end
                end
                CS_LOAD_ON: begin
                    if (!above_sleep_s && !above_wake_s) begin
                        state_next = CS_ASLEEP;
                    end
                end
                // the unused fourth code falls back to the safe always-on state
                default: begin
                    state_next = CS_FORCED_ON;
                end
            endcase
        end
    end

    // off only for standby and line high, with load below threshold except in role 05h
    assign conv_on_n_next = (state_next == CS_ASLEEP) & ~wake_low;

    // status readback
    assign status_byte = {2'b00,
                          any_fault,
                          drv_oe_reg & drv_out_reg,
                          drv_oe_reg & ~drv_out_reg,
                          state_reg == CS_LOAD_ON,
                          wake_s,
                          ~conv_on_n_reg};

    // command answer
    always_comb begin
        rsp_next = '0;
        if (cmd_wr) begin
            if (pec_good && (thr_cmd || (role_cmd && role_val_ok))) begin
                rsp_next.ack = 1'b1;
            end else begin
                rsp_next.nak = 1'b1;
            end
        end else if (cmd_rd) begin
            if (role_cmd) begin
                rsp_next.ack   = 1'b1;
                rsp_next.rdata = role_reg;
            end else if (thr_cmd) begin
                rsp_next.ack   = 1'b1;
                rsp_next.rdata = thr_rdata;
            end else if (stat_cmd) begin
                rsp_next.ack   = 1'b1;
                rsp_next.rdata = status_byte;
            end else begin
                rsp_next.nak = 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            role_reg      <= ROLE_RESET;
            state_reg     <= CS_FORCED_ON;
            wake_prev_reg <= 1'b0;
            conv_on_n_reg <= 1'b0;
            rsp_reg       <= '0;
        end else begin
            role_reg      <= role_next;
            state_reg     <= state_next;
            wake_prev_reg <= wake_s;
            conv_on_n_reg <= conv_on_n_next;
            rsp_reg       <= rsp_next;
        end
    end

    // wake line drive: low on fault, high only for a healthy active supply
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            drv_out_reg <= 1'b0;
            drv_oe_reg  <= 1'b0;
        end else if (any_fault) begin
            drv_out_reg <= 1'b0;
            drv_oe_reg  <= 1'b1;
        end else if (role_reg == ROLE_CR_ACTIVE) begin
            drv_out_reg <= 1'b1;
            drv_oe_reg  <= 1'b1;
        end else begin
            drv_out_reg <= 1'b0;
            drv_oe_reg  <= 1'b0;
        end
    end

    assign WAKE_LINE_OUT  = drv_out_reg;
    assign WAKE_LINE_OE   = drv_oe_reg;
    assign CONVERTER_ON_N = conv_on_n_reg;
    assign CMD_RSP        = rsp_reg;
endmodule
`default_nettype wire

/* test/crc_controller_monitor.sv */
// concurrent checks on the cold-redundancy controller ports
`default_nettype none
module crc_controller_monitor
    import crc_pkg::*;
(
    input  wire logic       MCLK,
    input  wire logic       RESET,
    input  wire crc_cmd_t   CMD_REQ,
    input  wire crc_rsp_t   CMD_RSP,
    input  wire logic       FAULT,
    input  wire logic       OUT_UNDERVOLT,
    input  wire logic       WAKE_LINE_IN,
    input  wire logic       WAKE_LINE_OUT,
    input  wire logic       WAKE_LINE_OE,
    input  wire logic [7:0] WAKE_THRESHOLD,
    input  wire logic       CONVERTER_ON_N
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RESET);

    property p_rst;
        disable iff (1'b0) RESET |=> !CONVERTER_ON_N && !WAKE_LINE_OE && CMD_RSP == '0
            && WAKE_THRESHOLD == THR_WAKE1_RST;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");

    property p_once;
        CMD_REQ.valid |=> CMD_RSP.ack != CMD_RSP.nak;
    endproperty
    a_once: assert property (p_once) else $error("not one answer per command");

    property p_idle;
        !CMD_REQ.valid |=> !CMD_RSP.ack && !CMD_RSP.nak;
    endproperty
    a_idle: assert property (p_idle) else $error("answer without command");

    property p_refuse;
        CMD_REQ.valid && CMD_REQ.write && (!CMD_REQ.pec_ok || CMD_REQ.code == CMD_STATUS
            || (CMD_REQ.code == CMD_ROLE && CMD_REQ.wdata > ROLE_ALWAYS_SB)) |=> CMD_RSP.nak;
    endproperty
    a_refuse: assert property (p_refuse) else $error("bad write not refused");

    property p_fault;
        (FAULT || OUT_UNDERVOLT) [*4] |=> WAKE_LINE_OE && !WAKE_LINE_OUT;
    endproperty
    a_fault: assert property (p_fault) else $error("fault does not pull line low");

    property p_wake;
        (!WAKE_LINE_IN) [*4] |=> !CONVERTER_ON_N;
    endproperty
    a_wake: assert property (p_wake) else $error("low line leaves converter off");

    property p_off;
        CONVERTER_ON_N |-> $past(WAKE_LINE_IN, 3);
    endproperty
    a_off: assert property (p_off) else $error("converter off without high line");

    property p_low;
        WAKE_LINE_OE && !WAKE_LINE_OUT |-> $past(FAULT, 3) || $past(OUT_UNDERVOLT, 3);
    endproperty
    a_low: assert property (p_low) else $error("line pulled low while healthy");

    property p_act;
        WAKE_LINE_OE && WAKE_LINE_OUT |-> !CONVERTER_ON_N;
    endproperty
    a_act: assert property (p_act) else $error("driving high with converter off");
endmodule

bind crc_controller crc_controller_monitor crc_controller_monitor_i (
    .MCLK,
    .RESET,
    .CMD_REQ,
    .CMD_RSP,
    .FAULT,
    .OUT_UNDERVOLT,
    .WAKE_LINE_IN,
    .WAKE_LINE_OUT,
    .WAKE_LINE_OE,
    .WAKE_THRESHOLD,
    .CONVERTER_ON_N
);
`default_nettype wire

/* test/crc_peer.sv */
// peer supplies on the shared wake line and the load-share comparators
`default_nettype none
module crc_peer (
    input  wire logic       drive_high,
    input  wire logic       drive_low,
    input  wire logic       dut_out,
    input  wire logic       dut_oe,
    input  wire logic [7:0] load_level,
    input  wire logic [7:0] wake_thr,
    input  wire logic [7:0] sleep_thr,
    output logic            wake_line,
    output logic            above_wake,
    output logic            above_sleep
);
    timeunit 1ns;
    timeprecision 1ns;
    wire any_low  = drive_low | (dut_oe & ~dut_out);
    wire any_high = drive_high | (dut_oe & dut_out);
    // undriven line falls to the weak pull-down
    assign wake_line   = any_low ? 1'b0 : any_high;
    assign above_wake  = load_level > wake_thr;
    assign above_sleep = load_level > sleep_thr;
endmodule
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the cold-redundancy controller
`default_nettype none
module tb;
    import crc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, fault, uv, peer_hi, peer_lo;
    logic        wl_in, wl_out, wl_oe, ab_w, ab_s, conv_n;
    logic [7:0]  load, wthr, sthr, w, s, code;
    logic [31:0] lfsr;
    crc_cmd_t    req;
    crc_rsp_t    rsp;
    int          error_cnt, check_count;

    crc_controller crc_controller_i (.MCLK(clk), .RESET(rst), .CMD_REQ(req), .CMD_RSP(rsp),
        .FAULT(fault), .OUT_UNDERVOLT(uv), .LOAD_ABOVE_WAKE(ab_w), .LOAD_ABOVE_SLEEP(ab_s),
        .WAKE_LINE_IN(wl_in), .WAKE_LINE_OUT(wl_out), .WAKE_LINE_OE(wl_oe),
        .WAKE_THRESHOLD(wthr), .SLEEP_THRESHOLD(sthr), .CONVERTER_ON_N(conv_n));
    crc_peer crc_peer_i (.drive_high(peer_hi), .drive_low(peer_lo), .dut_out(wl_out),
        .dut_oe(wl_oe), .load_level(load), .wake_thr(wthr), .sleep_thr(sthr),
        .wake_line(wl_in), .above_wake(ab_w), .above_sleep(ab_s));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // status byte expected for a healthy or faulty supply, active role or not
    function automatic logic [7:0] stat_exp(input logic bad, input logic act);
        logic [7:0] v;
        v = 8'h00;
        v[ST_CONV_ON]    = 1'b1;
        v[ST_WAKE_LEVEL] = !bad;
        v[ST_DRIVE_LOW]  = bad;
        v[ST_FAULT]      = bad;
        v[ST_DRIVE_HIGH] = act && !bad;
        return v;
    endfunction

    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask

    task automatic cmd(input logic wr, input logic pec, input logic [7:0] c,
                       input logic [7:0] wd, input logic ok, input logic [7:0] exp_rd);
        req = '{valid: 1'b1, write: wr, pec_ok: pec, code: c, wdata: wd};
        cyc(1);
        chk("ack", 8'(rsp.ack), 8'(ok));
        chk("nak", 8'(rsp.nak), 8'(!ok));
        if (ok && !wr) chk("rdata", rsp.rdata, exp_rd);
        req.valid = 1'b0;
        cyc(1);
    endtask

    task automatic conv_is(input logic exp_n, input int n);
        cyc(n);
        chk("conv", 8'(conv_n), 8'(exp_n));
    endtask

    initial begin
        #1_000_000;
        error_cnt++;
        final_report;
    end

    initial begin
        {error_cnt, check_count} = '0;
        {rst, fault, uv, peer_hi, peer_lo} = 5'b10000;
        req = '0;
        load = 8'h00;
        lfsr = 32'h184b4837;
        cyc(4);
        rst = 1'b0;
        cmd(0, 1, CMD_ROLE, 8'h00, 1, ROLE_RESET);
        chk("conv", 8'(conv_n), 8'h00);
        chk("wthr", wthr, THR_WAKE1_RST);
        chk("sthr", sthr, THR_SLEEP1_RST);
        $display("test reset done");
        cmd(1, 0, CMD_ROLE, 8'h02, 0, 8'h00);
        cmd(1, 1, CMD_ROLE, 8'h06, 0, 8'h00);
        cmd(1, 1, CMD_STATUS, 8'h00, 0, 8'h00);
        cmd(0, 1, 8'h42, 8'h00, 0, 8'h00);
        cmd(0, 1, CMD_ROLE, 8'h00, 1, ROLE_RESET);
        $display("test refuse done");
        peer_hi = 1'b1;
        for (int r = 0; r < 6; r++) begin
            cmd(1, 1, CMD_ROLE, 8'(r), 1, 8'h00);
            conv_is(r >= 2, 4);
            cmd(0, 1, CMD_ROLE, 8'h00, 1, 8'(r));
            chk("oe", 8'(wl_oe), 8'(r == 1));
            if (r >= 2 && r <= 4) begin
                chk("wthr", wthr, THR_RST_VEC[(r-2)*16 +: 8]);
                chk("sthr", sthr, THR_RST_VEC[(r-2)*16+8 +: 8]);
            end
        end
        $display("test roles done");
        for (int r = 2; r < 5; r++) begin
            w = THR_RST_VEC[(r-2)*16 +: 8];
            s = THR_RST_VEC[(r-2)*16+8 +: 8];
            cmd(1, 1, CMD_ROLE, 8'(r), 1, 8'h00);
            load = w;
            conv_is(1'b1, 5);
            load = w + 8'h01;
            conv_is(1'b0, 5);
            load = s + 8'h01;
            conv_is(1'b0, 5);
            load = s;
            conv_is(1'b1, 5);
        end
        cmd(1, 1, CMD_ROLE, ROLE_ALWAYS_SB, 1, 8'h00);
        load = 8'hff;
        conv_is(1'b1, 5);
        load = 8'h00;
        $display("test load done");
        repeat (6) begin
            lfsr = lfsr_next(lfsr);
            code = CMD_WAKE_POS1 + 8'(lfsr[2:0] % 6);
            cmd(1, 1, code, lfsr[15:8], 1, 8'h00);
            cmd(0, 1, code, 8'h00, 1, lfsr[15:8]);
        end
        $display("test thresholds done");
        cmd(1, 1, CMD_ROLE, ROLE_STBY1, 1, 8'h00);
        conv_is(1'b1, 4);
        peer_lo = 1'b1;
        conv_is(1'b0, 4);
        cmd(0, 1, CMD_ROLE, 8'h00, 1, ROLE_STANDARD);
        peer_lo = 1'b0;
        conv_is(1'b0, 4);
        // host must program the role again after a wake
        cmd(1, 1, CMD_ROLE, ROLE_STBY1, 1, 8'h00);
        conv_is(1'b1, 4);
        $display("test wake done");
        cmd(1, 1, CMD_ROLE, ROLE_STANDARD, 1, 8'h00);
        peer_hi = 1'b0;
        cyc(4);
        cmd(1, 1, CMD_ROLE, ROLE_STBY1, 1, 8'h00);
        conv_is(1'b0, 4);
        cmd(0, 1, CMD_ROLE, 8'h00, 1, ROLE_STBY1);
        $display("test no active done");
        peer_hi = 1'b1;
        cmd(1, 1, CMD_ROLE, ROLE_CR_ACTIVE, 1, 8'h00);
        for (int k = 0; k < 6; k++) begin
            if (k == 3) cmd(1, 1, CMD_ROLE, ROLE_STANDARD, 1, 8'h00);
            fault = (k % 3 == 1);
            uv = (k % 3 == 2);
            cyc(5);
            chk("oe", 8'(wl_oe), 8'(k != 3));
            chk("out", 8'(wl_out), 8'(k == 0));
            chk("conv", 8'(conv_n), 8'h00);
            cmd(0, 1, CMD_STATUS, 8'h00, 1, stat_exp(fault | uv, k < 3));
        end
        $display("test drive done");
        // second reset in mid-run: role, thresholds and drive return to defaults
        fault = 1'b0;
        uv = 1'b0;
        rst = 1'b1;
        cyc(4);
        rst = 1'b0;
        cmd(0, 1, CMD_ROLE, 8'h00, 1, ROLE_RESET);
        cmd(0, 1, CMD_WAKE_POS1, 8'h00, 1, THR_WAKE1_RST);
        chk("wthr", wthr, THR_WAKE1_RST);
        chk("oe", 8'(wl_oe), 8'h00);
        chk("conv", 8'(conv_n), 8'h00);
        $display("test reset again done");
        final_report;
    end
endmodule
`default_nettype wire
